// *** include/adcc_pkg.sv ***
package adcc_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [11:0] IDX_CONV_CTRL = 12'h3F3;
  localparam logic [11:0] IDX_PAIR_CTRL = 12'h3F4;
  localparam logic [11:0] IDX_COMP_CTRL = 12'h3F5;
  localparam logic [11:0] IDX_ERR_CTRL = 12'h3F6;
  localparam logic [11:0] IDX_STATUS = 12'h3F7;
  localparam logic [11:0] IDX_SETPOINT = 12'h3E0;
  localparam logic [11:0] IDX_UPPER_TH = 12'h3E1;
  localparam logic [11:0] IDX_LOWER_TH = 12'h3E2;
  localparam logic [11:0] IDX_REPEAT = 12'h3E3;
  localparam logic [11:0] IDX_CONV_RES = 12'h3E4;
  localparam logic [11:0] IDX_PREV_RES = 12'h3E5;
  localparam logic [11:0] IDX_FILT_RES = 12'h3E6;
  localparam logic [11:0] IDX_ERROR = 12'h3E7;
  localparam logic [11:0] IDX_ACCUM = 12'h3E8;
  localparam logic [11:0] IDX_COUNT = 12'h3E9;

  // Field positions
  localparam int unsigned POS_GO = 0;
  localparam int unsigned POS_CONTINUOUS_FLAG = 6;
  localparam int unsigned POS_PAIR = 0;
  localparam int unsigned POS_PREVIOUS_SOURCE_SELECT = 7;
  localparam int unsigned POS_SHIFT = 4;
  localparam int unsigned POS_ACCUMULATOR_CLEAR = 3;
  localparam int unsigned POS_MODE = 0;
  localparam int unsigned POS_ERROR_SELECT_A = 4;
  localparam int unsigned POS_SOI = 3;
  localparam int unsigned POS_TMD = 0;
  localparam int unsigned POS_AOV = 7;
  localparam int unsigned POS_UPPER_THRESHOLD_FLAG = 6;
  localparam int unsigned POS_LOWER_THRESHOLD_FLAG = 5;
  localparam int unsigned POS_COMPUTATION_UPDATED_FLAG = 4;

  // Values after reset and the accumulator clear time
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam int unsigned CLR_TIME_NS = 16;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam logic [3:0] CLR_CYCLES = 4'(CLR_TIME_NS / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    MODE_BASIC = 3'b000,
    MODE_ACCUM = 3'b001,
    MODE_AVG = 3'b010,
    MODE_BURST = 3'b011,
    MODE_LPF = 3'b100
  } adcc_mode_e;

  typedef enum logic [2:0] {
    STG_IDLE = 3'b000,
    STG_HOLD = 3'b100
  } adcc_stage_e;

  // Converter core handshake
  typedef struct packed {
    logic start;
    logic done;
    logic [1:0] phase;
    logic [11:0] data;
  } adcc_conv_s;

endpackage : adcc_pkg

// *** hdl/adcc_compute.sv ***
// What this block does
// - Paired mode computes after second conversion
// - Single mode computes after every conversion
// - Start loads previous from filter or result
// - Filter mode constant two to shift_select
// - Accumulating modes right-shift by shift_select
// - Basic mode ignores shift_select
// - Clear empties accumulator, count, overflow
// - Hardware drops accumulator_clear when finished
// - Three-bit computation_mode, codes 101-111 reserved
// - error_select_a picks error_value formula
// - Paired, result source: error every second
// - Stop on threshold clears go flag
// - Without stop, software clears go flag
// - threshold_irq_mode selects interrupt condition
// - Overflow sets accum_overflow_flag
// - Read-only upper and lower threshold flags
// - Updated flag, clear ignored in hold
// - cycle_stage reports precharge/acquire/convert/hold
// - Hold stage between paired triggers
// - Stage may be invalid on fast RC
// - Continuous mode retriggers after each conversion
module adcc_compute
  import adcc_pkg::*;
#(
  parameter int unsigned ACC_W = 18
)
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter core
  input wire adcc_conv_s conv_in,
  output logic conv_go,
  output logic [2:0] cycle_stage,
  // Events
  output logic threshold_event,
  output logic computation_done
);

  logic go_ff, continuous_flag_ff, pair_ff, previous_source_select_ff, accumulator_clear_ff, soi_ff;
  logic [2:0] shift_ff, mode_ff, error_select_a_ff, tmd_ff, stage_ff;
  logic aov_ff, computation_updated_flag_ff, second_ff, thr_evt_ff, done_evt_ff;
  logic [15:0] setpoint_ff, uth_ff, lth_ff, prev_ff, filt_ff, err_ff;
  logic [11:0] res_ff;
  logic [7:0] rpt_ff, cnt_ff;
  logic [ACC_W-1:0] acc_ff;
  logic [3:0] clr_cnt_ff;
  logic [31:0] prdata_ff;

  // Sign-extend to the wide working width
  function automatic logic signed [ACC_W:0] wide(input logic [16:0] v);
    wide = {{(ACC_W-16){v[16]}}, v};
  endfunction : wide

  // True when a wide value fits a signed 16-bit register
  function automatic logic fits16(input logic [ACC_W:0] v);
    fits16 = (v[ACC_W:15] == {(ACC_W-14){1'b0}}) || (v[ACC_W:15] == {(ACC_W-14){1'b1}});
  endfunction : fits16

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // Bus decode
  logic [11:0] idx;
  logic setup, wr, wr0, mapped;
  assign idx = paddr[13:2];
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign wr0 = wr & pstrb[0];
  assign mapped = (idx >= IDX_SETPOINT && idx <= IDX_COUNT)
                  || (idx >= IDX_CONV_CTRL && idx <= IDX_STATUS);
  // Zero wait states keep every access two cycles long
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_ff;

  // Conversion events
  logic comp, first;
  assign comp = conv_in.done & go_ff & (~pair_ff | second_ff);
  assign first = conv_in.done & go_ff & pair_ff & ~second_ff;

  // Sample value: paired mode works on the result difference
  logic [16:0] res17, samp17, prev17;
  assign res17 = {5'h00, conv_in.data};
  assign prev17 = {prev_ff[15], prev_ff};
  assign samp17 = pair_ff ? 17'(res17 - prev17) : res17;

  // Accumulator and filter arithmetic
  logic restart, acc_ovf;
  logic [ACC_W-1:0] acc_base;
  logic [ACC_W:0] acc_sum, filt_wide;
  logic [15:0] filt_nxt;
  logic ovf_filt;
  logic signed [ACC_W-1:0] acc_shr;
  always_comb
  begin
    // Shift kept apart so an unsigned operand cannot turn it logical
    acc_shr = $signed(acc_ff) >>> shift_ff;
    restart = (mode_ff == MODE_AVG || mode_ff == MODE_BURST)
              && rpt_ff != 8'h00 && cnt_ff >= rpt_ff;
    acc_base = acc_ff;
    if (restart)
      acc_base = '0;
    if (mode_ff == MODE_LPF)
      acc_base = ACC_W'(acc_ff - acc_shr);
    acc_sum = ACC_W'(0) + {acc_base[ACC_W-1], acc_base} + wide(samp17);
    acc_ovf = acc_sum[ACC_W] != acc_sum[ACC_W-1];
    filt_wide = ($signed({acc_sum[ACC_W-1], acc_sum[ACC_W-1:0]}) >>> shift_ff);
    ovf_filt = ~fits16(filt_wide);
    filt_nxt = (mode_ff == MODE_BASIC) ? filt_ff : filt_wide[15:0];
  end

  // Error selection
  logic [ACC_W:0] err_wide;
  logic [15:0] err_nxt;
  logic ovf_err, hit;
  always_comb
  begin
    unique case (error_select_a_ff)
      3'b101: err_wide = wide({filt_nxt[15], filt_nxt}) - wide({setpoint_ff[15], setpoint_ff});
      3'b100: err_wide = wide(prev17) - wide({filt_nxt[15], filt_nxt});
      3'b010: err_wide = wide(samp17) - wide({filt_nxt[15], filt_nxt});
      3'b001: err_wide = wide(samp17) - wide({setpoint_ff[15], setpoint_ff});
      3'b000: err_wide = wide(res17) - wide(prev17);
      default: err_wide = '0;
    endcase
    ovf_err = ~fits16(err_wide);
    err_nxt = err_wide[15:0];
    unique case (tmd_ff)
      3'b000: hit = 1'b0;
      3'b001: hit = $signed(err_nxt) < $signed(lth_ff);
      3'b010: hit = $signed(err_nxt) >= $signed(lth_ff);
      3'b011: hit = $signed(err_nxt) > $signed(lth_ff) && $signed(err_nxt) < $signed(uth_ff);
      3'b100: hit = $signed(err_nxt) < $signed(lth_ff) || $signed(err_nxt) > $signed(uth_ff);
      3'b101: hit = $signed(err_nxt) <= $signed(uth_ff);
      3'b110: hit = $signed(err_nxt) > $signed(uth_ff);
      3'b111: hit = 1'b1;
    endcase
  end

  // Threshold flags follow the stored error value
  logic upper_threshold_flag, lower_threshold_flag;
  assign upper_threshold_flag = $signed(err_ff) > $signed(uth_ff);
  assign lower_threshold_flag = $signed(err_ff) < $signed(lth_ff);

  // Go flag, continuous and pair configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      go_ff <= 1'b0;
      continuous_flag_ff <= 1'b0;
      pair_ff <= 1'b0;
    end
    else
    begin
      if (wr0 && idx == IDX_PAIR_CTRL)
        pair_ff <= pwdata[POS_PAIR];
      if (wr0 && idx == IDX_CONV_CTRL)
      begin
        continuous_flag_ff <= pwdata[POS_CONTINUOUS_FLAG];
        go_ff <= pwdata[POS_GO];
      end
      else if (conv_in.done && go_ff)
      begin
        // single trigger ends after first of pair
        if (!continuous_flag_ff)
          go_ff <= 1'b0;
        else if (soi_ff && comp && hit)
          go_ff <= 1'b0;
      end
    end
  end

  // Computation and threshold control fields
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      previous_source_select_ff <= 1'b0;
      shift_ff <= 3'h0;
      mode_ff <= 3'h0;
      error_select_a_ff <= 3'h0;
      soi_ff <= 1'b0;
      tmd_ff <= 3'h0;
    end
    else
    begin
      if (wr0 && idx == IDX_COMP_CTRL)
      begin
        previous_source_select_ff <= pwdata[POS_PREVIOUS_SOURCE_SELECT];
        shift_ff <= pwdata[POS_SHIFT +: 3];
        // reserved codes are stored as written
        mode_ff <= pwdata[POS_MODE +: 3];
      end
      if (wr0 && idx == IDX_ERR_CTRL)
      begin
        error_select_a_ff <= pwdata[POS_ERROR_SELECT_A +: 3];
        soi_ff <= pwdata[POS_SOI];
        tmd_ff <= pwdata[POS_TMD +: 3];
      end
    end
  end

  // Accumulator clear command; it runs several cycles so software polls it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      accumulator_clear_ff <= 1'b0;
      clr_cnt_ff <= 4'h0;
    end
    else if (wr0 && idx == IDX_COMP_CTRL && pwdata[POS_ACCUMULATOR_CLEAR])
    begin
      accumulator_clear_ff <= 1'b1;
      clr_cnt_ff <= CLR_CYCLES;
    end
    else if (accumulator_clear_ff)
    begin
      clr_cnt_ff <= clr_cnt_ff - 4'h1;
      if (clr_cnt_ff <= 4'h1)
        accumulator_clear_ff <= 1'b0;
    end
  end

  logic clr_done;
  assign clr_done = accumulator_clear_ff && clr_cnt_ff <= 4'h1;

  // Software-written data registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      setpoint_ff <= RST_WORD;
      uth_ff <= RST_WORD;
      lth_ff <= RST_WORD;
      rpt_ff <= RST_BYTE;
    end
    else if (wr)
    begin
      if (idx == IDX_SETPOINT)
        setpoint_ff <= merge16(setpoint_ff, pwdata, pstrb);
      if (idx == IDX_UPPER_TH)
        uth_ff <= merge16(uth_ff, pwdata, pstrb);
      if (idx == IDX_LOWER_TH)
        lth_ff <= merge16(lth_ff, pwdata, pstrb);
      if (idx == IDX_REPEAT && pstrb[0])
        rpt_ff <= pwdata[7:0];
    end
  end

  // Result and previous-result registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res_ff <= 12'h000;
      prev_ff <= RST_WORD;
    end
    else
    begin
      if (conv_in.done)
        res_ff <= conv_in.data;
      if (conv_in.start)
        prev_ff <= previous_source_select_ff ? filt_ff : {4'h0, res_ff};
    end
  end

  // Pair tracking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      second_ff <= 1'b0;
    else if (first)
      second_ff <= 1'b1;
    else if (comp || !pair_ff)
      second_ff <= 1'b0;
  end

  // Accumulator, count, filter and error; a clear yields to a same-cycle update
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_ff <= '0;
      cnt_ff <= RST_BYTE;
      filt_ff <= RST_WORD;
      err_ff <= RST_WORD;
    end
    else if (comp)
    begin
      if (mode_ff != MODE_BASIC)
      begin
        acc_ff <= acc_sum[ACC_W-1:0];
        if (restart)
          cnt_ff <= 8'h01;
        else if (cnt_ff != 8'hFF)
          cnt_ff <= cnt_ff + 8'h01;
      end
      filt_ff <= filt_nxt;
      err_ff <= err_nxt;
    end
    else if (clr_done)
    begin
      acc_ff <= '0;
      cnt_ff <= RST_BYTE;
    end
  end

  // Overflow and updated flags: hardware set wins over any clear
  logic sw_st_wr, ovf_any;
  assign sw_st_wr = wr0 && idx == IDX_STATUS;
  assign ovf_any = comp && ((mode_ff != MODE_BASIC && (acc_ovf || ovf_filt)) || ovf_err);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aov_ff <= 1'b0;
      computation_updated_flag_ff <= 1'b0;
    end
    else
    begin
      if (ovf_any)
        aov_ff <= 1'b1;
      else if (clr_done || (sw_st_wr && !pwdata[POS_AOV]))
        aov_ff <= 1'b0;
      if (comp || ovf_any)
        computation_updated_flag_ff <= 1'b1;
      else if (sw_st_wr && !pwdata[POS_COMPUTATION_UPDATED_FLAG] && stage_ff != STG_HOLD)
        computation_updated_flag_ff <= 1'b0;
    end
  end

  // Stage indicator; converter phase is taken as synchronous to pclk,
  // so a converter clocked faster than pclk may show stale phases
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stage_ff <= STG_IDLE;
    else if (go_ff && conv_in.phase != 2'b00)
      stage_ff <= {second_ff, conv_in.phase};
    else if (second_ff)
      stage_ff <= STG_HOLD;
    else
      stage_ff <= STG_IDLE;
  end

  // Event pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      thr_evt_ff <= 1'b0;
      done_evt_ff <= 1'b0;
    end
    else
    begin
      thr_evt_ff <= comp & hit;
      done_evt_ff <= comp;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h0000_0000;
    else if (setup && !pwrite)
    begin
      prdata_ff <= 32'h0000_0000;
      unique case (idx)
        IDX_CONV_CTRL: prdata_ff[7:0] <= {1'b0, continuous_flag_ff, 5'h00, go_ff};
        IDX_PAIR_CTRL: prdata_ff[7:0] <= {7'h00, pair_ff};
        IDX_COMP_CTRL: prdata_ff[7:0] <= {previous_source_select_ff, shift_ff, accumulator_clear_ff, mode_ff};
        IDX_ERR_CTRL: prdata_ff[7:0] <= {1'b0, error_select_a_ff, soi_ff, tmd_ff};
        IDX_STATUS: prdata_ff[7:0] <= {aov_ff, upper_threshold_flag, lower_threshold_flag, computation_updated_flag_ff, 1'b0, stage_ff};
        IDX_SETPOINT: prdata_ff[15:0] <= setpoint_ff;
        IDX_UPPER_TH: prdata_ff[15:0] <= uth_ff;
        IDX_LOWER_TH: prdata_ff[15:0] <= lth_ff;
        IDX_REPEAT: prdata_ff[7:0] <= rpt_ff;
        IDX_CONV_RES: prdata_ff[11:0] <= res_ff;
        IDX_PREV_RES: prdata_ff[15:0] <= prev_ff;
        IDX_FILT_RES: prdata_ff[15:0] <= filt_ff;
        IDX_ERROR: prdata_ff[15:0] <= err_ff;
        IDX_ACCUM: prdata_ff[ACC_W-1:0] <= acc_ff;
        IDX_COUNT: prdata_ff[7:0] <= cnt_ff;
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Converter-facing and event outputs
  assign conv_go = go_ff;
  assign cycle_stage = stage_ff;
  assign threshold_event = thr_evt_ff;
  assign computation_done = done_evt_ff;

endmodule : adcc_compute

// *** tb/adcc_compute_checker.sv ***
module adcc_compute_checker
  import adcc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [15:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Converter side and events
  input wire adcc_conv_s conv_in,
  input wire logic conv_go,
  input wire logic [2:0] cycle_stage,
  input wire logic threshold_event,
  input wire logic computation_done
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic acc;
  logic mapped;
  // Implemented word indices form two contiguous windows
  assign acc = psel && penable;
  assign mapped = (paddr[13:2] >= IDX_SETPOINT && paddr[13:2] <= IDX_COUNT) ||
    (paddr[13:2] >= IDX_CONV_CTRL && paddr[13:2] <= IDX_STATUS);

  a_zero_wait: assert property (acc |-> pready)
    else $error("access phase without ready");
  a_unmapped_error: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access not flagged");
  a_mapped_ok: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access flagged");
  a_compute_after_done: assert property (
    computation_done |-> $past(conv_in.done) || $past(conv_in.done, 2))
    else $error("computation without a finished conversion");
  a_hold_no_compute: assert property (cycle_stage == 3'b100 |-> !computation_done)
    else $error("computation during pair hold");
  a_event_with_done: assert property (threshold_event |-> computation_done)
    else $error("threshold event outside computation");
  a_go_fall_cause: assert property (
    $fell(conv_go) |-> $past(conv_in.done) || $past(conv_in.done, 2) || $past(acc))
    else $error("go flag dropped without cause");
  a_stage_follow: assert property (
    conv_in.phase != 2'd0 && conv_go |=> cycle_stage[1:0] == $past(conv_in.phase))
    else $error("stage does not follow phase");
  a_hold_after_conv: assert property (
    $rose(cycle_stage == 3'b100) |->
      $past(conv_in.done) || $past(conv_in.done, 2) || $past(conv_in.done, 3))
    else $error("hold stage without first conversion");

  c_done: cover property (computation_done);
  c_event: cover property (threshold_event);
  c_hold: cover property (cycle_stage == 3'b100);
  c_refused: cover property (pslverr);
endmodule : adcc_compute_checker

bind adcc_compute adcc_compute_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .conv_in(conv_in),
  .conv_go(conv_go), .cycle_stage(cycle_stage), .threshold_event(threshold_event),
  .computation_done(computation_done));

// *** tb/tb_adcc_compute.sv ***
module tb_adcc_compute
  import adcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic conv_go, threshold_event, computation_done;
  logic [2:0] cycle_stage;
  logic [7:0] cctl;
  adcc_conv_s conv_in;
  int miscompares, total_checks, ndone, nthr;
  int vals [4] = '{30, 50, 100, 150};
  logic [11:0] ridx [3] = '{IDX_COMP_CTRL, IDX_ERR_CTRL, IDX_STATUS};

  adcc_compute u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_in(conv_in), .conv_go(conv_go),
    .cycle_stage(cycle_stage), .threshold_event(threshold_event),
    .computation_done(computation_done));

  // Free-running 250 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  // One transfer; an idle edge follows so back-to-back calls never re-drive psel
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Arm go, run one conversion, then count event pulses over a short window
  task automatic conv(input logic [11:0] d, input logic [2:0] st);
    apb(1'b1, IDX_CONV_CTRL, {24'h0, cctl});
    conv_in.start <= 1'b1;
    conv_in.phase <= 2'd1;
    @(posedge pclk);
    conv_in.start <= 1'b0;
    conv_in.phase <= 2'd3;
    @(posedge pclk);
    conv_in.done <= 1'b1;
    conv_in.data <= d;
    #1;
    chk("stage", {29'h0, cycle_stage}, {29'h0, st});
    @(posedge pclk);
    conv_in.done <= 1'b0;
    conv_in.phase <= 2'd0;
    conv_in.data <= ~d;
    ndone = 0;
    nthr = 0;
    repeat (4)
    begin
      #1;
      ndone += int'(computation_done === 1'b1);
      nthr += int'(threshold_event === 1'b1);
      @(posedge pclk);
    end
  endtask : conv

  // Start a clear, expect it busy, poll it down, then expect an empty accumulator
  task automatic clear_acc(input logic [7:0] ctl);
    apb(1'b1, IDX_COMP_CTRL, {24'h0, ctl | 8'h08});
    apb(1'b0, IDX_COMP_CTRL, 32'h0);
    chk("clear busy", {31'h0, rd[3]}, 32'h1);
    for (int k = 0; k < 8 && rd[3] === 1'b1; k++)
      apb(1'b0, IDX_COMP_CTRL, 32'h0);
    chk("clear done", rd, {24'h0, ctl});
    apb(1'b0, IDX_ACCUM, 32'h0);
    chk("accumulator", rd, 32'h0);
    apb(1'b0, IDX_COUNT, 32'h0);
    chk("count", rd, 32'h0);
  endtask : clear_acc

  function automatic logic thr(input int m, input int v);
    case (m)
      0: return 1'b0;
      1: return v < 50;
      2: return v >= 50;
      3: return v > 50 && v < 100;
      4: return v < 50 || v > 100;
      5: return v <= 100;
      6: return v > 100;
      default: return 1'b1;
    endcase
  endfunction : thr

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // Hang guard, far beyond the roughly one thousand cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    final_report();
  end

  // Main sequence
  initial
  begin
    miscompares = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    conv_in = '0;
    cctl = 8'h01;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ridx[i])
    begin
      apb(1'b0, ridx[i], 32'h0);
      chk("reset value", rd, 32'h0);
    end
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    // Every threshold mode against values below, on and above both limits
    apb(1'b1, IDX_UPPER_TH, 32'd100);
    apb(1'b1, IDX_LOWER_TH, 32'd50);
    for (int m = 0; m < 8; m++)
      foreach (vals[i])
      begin
        apb(1'b1, IDX_ERR_CTRL, 32'(8'h10 | 8'(m)));
        conv(vals[i][11:0], 3'b011);
        chk("single compute", 32'(ndone), 32'h1);
        chk("threshold event", 32'(nthr), 32'(thr(m, vals[i])));
        apb(1'b0, IDX_ERROR, 32'h0);
        chk("error value", rd, 32'(vals[i]));
        apb(1'b0, IDX_STATUS, 32'h0);
        chk("limit flags", {30'h0, rd[6:5]}, {30'h0, vals[i] > 100, vals[i] < 50});
      end
    // Difference from the previous result
    apb(1'b1, IDX_ERR_CTRL, 32'h0);
    conv(12'd200, 3'b011);
    conv(12'd260, 3'b011);
    apb(1'b0, IDX_PREV_RES, 32'h0);
    chk("previous", rd, 32'd200);
    apb(1'b0, IDX_ERROR, 32'h0);
    chk("difference", rd, 32'd60);
    // Accumulate with a shift of one, then clear
    clear_acc(8'h11);
    conv(12'd10, 3'b011);
    conv(12'd20, 3'b011);
    apb(1'b0, IDX_ACCUM, 32'h0);
    chk("sum", rd, 32'd30);
    apb(1'b0, IDX_COUNT, 32'h0);
    chk("samples", rd, 32'd2);
    apb(1'b0, IDX_FILT_RES, 32'h0);
    chk("shifted", rd, 32'd15);
    clear_acc(8'h11);
    // Low-pass filter with a time constant of two
    clear_acc(8'h14);
    conv(12'd100, 3'b011);
    conv(12'd100, 3'b011);
    apb(1'b0, IDX_FILT_RES, 32'h0);
    chk("filter", rd, 32'd75);
    // Average over two samples, then restart
    apb(1'b1, IDX_REPEAT, 32'd2);
    clear_acc(8'h12);
    conv(12'd10, 3'b011);
    conv(12'd20, 3'b011);
    apb(1'b0, IDX_FILT_RES, 32'h0);
    chk("average", rd, 32'd15);
    conv(12'd40, 3'b011);
    apb(1'b0, IDX_COUNT, 32'h0);
    chk("restart count", rd, 32'd1);
    // Burst average with an error overflow; a clear drops the flag
    apb(1'b1, IDX_SETPOINT, 32'h8000);
    apb(1'b1, IDX_ERR_CTRL, 32'h10);
    clear_acc(8'h13);
    conv(12'hFFF, 3'b011);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("overflow", {31'h0, rd[7]}, 32'h1);
    apb(1'b0, IDX_FILT_RES, 32'h0);
    chk("burst", rd, 32'd2047);
    clear_acc(8'h13);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("overflow cleared", {31'h0, rd[7]}, 32'h0);
    apb(1'b1, IDX_ERR_CTRL, 32'h0);
    // Paired conversions, with a refused flag clear during the hold
    apb(1'b1, IDX_COMP_CTRL, 32'h0);
    apb(1'b1, IDX_PAIR_CTRL, 32'h1);
    conv(12'd100, 3'b011);
    chk("first of pair", 32'(ndone), 32'h0);
    apb(1'b1, IDX_STATUS, 32'h0);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("hold status", {27'h0, rd[4:0]}, 32'h14);
    conv(12'd180, 3'b111);
    chk("second of pair", 32'(ndone), 32'h1);
    apb(1'b1, IDX_PAIR_CTRL, 32'h0);
    apb(1'b1, IDX_STATUS, 32'h0);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("idle status", {27'h0, rd[4:0]}, 32'h0);
    // Continuous operation with and without stop on threshold
    cctl = 8'h41;
    apb(1'b1, IDX_ERR_CTRL, 32'h0F);
    conv(12'd5, 3'b011);
    chk("stop on hit", {31'h0, conv_go}, 32'h0);
    apb(1'b1, IDX_ERR_CTRL, 32'h07);
    conv(12'd5, 3'b011);
    chk("retrigger", {31'h0, conv_go}, 32'h1);
    apb(1'b1, IDX_CONV_CTRL, 32'h0);
    chk("software stop", {31'h0, conv_go}, 32'h0);
    final_report();
  end
endmodule : tb_adcc_compute
